// File: shared/gdfs_pkg.sv
// Package of constants and types for the general I/O debounce and frame sync block.
// ==========================================================================
// Function
// - The general output pin follows the output-value register, high when true and low when false.
// - The line-state register reads true while the filtered general input is asserted and false otherwise.
// - Writing value 2 to the routing variable register connects the general input to the event logic.
// - Writing value 5 to the event selector register selects the logic interrupt queue as event source.
// - Writing value 3 to the notification register enables protocol event messages; other values do not.
// - When configured, every change of the general input state emits one protocol event message.
// - The debounce register sets the filter window in steps of about 480 ns and drops shorter transitions.
// - The debounce register resets to zero and a zero value bypasses filtering entirely.
// - The debounce register accepts values up to 65535, a window of about 31 ms.
// - An external sync channel aligns frame start between master and slave cameras or other equipment.
// - Sync pulses are at least 100 ns wide and each accepted pulse is stretched to one microsecond.
// - The sync mode is not kept over reset and always comes up disabled.
// - In the slow 9 Hz configuration frames start on a fraction of the sync pulses.
// - External master mode relays each received sync pulse to the sync output; follower mode does not.
package gdfs_pkg;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] ADDR_OUTPUT_VALUE  = 8'h00;
  localparam logic [7:0] ADDR_LINE_STATE    = 8'h04;
  localparam logic [7:0] ADDR_ROUTE_VAR     = 8'h08;
  localparam logic [7:0] ADDR_EVENT_SELECT  = 8'h0c;
  localparam logic [7:0] ADDR_NOTIFY_MODE   = 8'h10;
  localparam logic [7:0] ADDR_FILTER_WINDOW = 8'h14;
  localparam logic [7:0] ADDR_SYNC_SETTING  = 8'h18;
  localparam logic [7:0] ADDR_SLOW_DIVIDER  = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h24;
  localparam logic [7:0] ADDR_EVENT_COUNT   = 8'h28;

  // ==========================================================================
  // Enumeration values that arm the event path, and the 32-bit zero reset value.
  localparam logic [31:0] ROUTE_LOGIC_INPUT_ZERO   = 32'h0000_0002;
  localparam logic [31:0] SOURCE_LOGIC_IRQ_QUEUE   = 32'h0000_0005;
  localparam logic [31:0] NOTIFY_VISION_EVENT      = 32'h0000_0003;
  localparam logic [31:0] RESET_ZERO32             = 32'h0000_0000;

  // ==========================================================================
  // Sync setting codes and interrupt bit positions.
  localparam logic [1:0] SYNC_DISABLED       = 2'h0;
  localparam logic [1:0] SYNC_FOLLOWER       = 2'h1;
  localparam logic [1:0] SYNC_MASTER_RELAY   = 2'h2;
  localparam int IRQ_BIT_INPUT_EVENT = 0;
  localparam int IRQ_BIT_SYNC_PULSE  = 1;
  localparam int IRQ_BIT_FRAME_START = 2;
  localparam int IRQ_WIDTH           = 3;

  // ==========================================================================
  // Timing: clock 100 MHz.
  localparam int CLK_PERIOD_PS     = 10000;
  localparam int FILTER_STEP_PS    = 480000;
  localparam int STRETCH_WIDTH_PS  = 1000000;
  localparam int MIN_SYNC_PULSE_PS = 100000;
  localparam int FILTER_STEP_CYC   = FILTER_STEP_PS / CLK_PERIOD_PS;
  localparam int STRETCH_CYC       = STRETCH_WIDTH_PS / CLK_PERIOD_PS;
  localparam int MIN_SYNC_CYC      = (MIN_SYNC_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [15:0] FILTER_WINDOW_MAX = 16'hffff;

  typedef enum logic [1:0] {
    GDFS_AXI_IDLE,
    GDFS_AXI_RESP
  } gdfs_wr_state_t;

endpackage

// File: verilog/gdfs_top.sv
// General I/O with debounce, event generation and external frame sync, behind AXI4-Lite.
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module gdfs_top
  import gdfs_pkg::*;
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  input  wire logic        I_GENERAL_INPUT_POSITIVE,
  output logic             O_GENERAL_OUTPUT_POSITIVE,
  input  wire logic        I_SYNC_IN,
  output logic             O_SYNC_OUT,
  output logic             O_FRAME_START,
  output logic             O_VISION_PROTOCOL_EVENT,
  output logic             O_EVENT_LEVEL,
  output logic             O_IRQ
);

  // ==========================================================================
  // Registers.
  logic                 general_output_value_reg;
  logic [31:0]          logic_route_variable_reg;
  logic [31:0]          event_source_select_reg;
  logic [31:0]          event_notify_mode_reg;
  logic [15:0]          input_filter_window_reg;
  logic [1:0]           frame_sync_setting_reg;
  logic [7:0]           slow_divider_reg;
  logic [IRQ_WIDTH-1:0] irq_status_reg;
  logic [IRQ_WIDTH-1:0] irq_mask_reg;
  logic [15:0]          event_count_reg;

  // ==========================================================================
  // Input synchronisers.
  // Only the second stage feeds logic, because the first may still be settling.
  logic [1:0] gpi_sync_reg;
  logic [1:0] sync_in_sync_reg;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      gpi_sync_reg     <= 2'h0;
      sync_in_sync_reg <= 2'h0;
    end else begin
      gpi_sync_reg     <= {gpi_sync_reg[0], I_GENERAL_INPUT_POSITIVE};
      sync_in_sync_reg <= {sync_in_sync_reg[0], I_SYNC_IN};
    end
  end

  logic gpi_raw;
  logic sync_raw;
  assign gpi_raw  = gpi_sync_reg[1];
  assign sync_raw = sync_in_sync_reg[1];

  // ==========================================================================
  // Debounce filter: the window is counted as whole steps of a prescaler.
  // Any return of the raw level restarts both counters, so a bounce anywhere restarts the full window.
  logic        filtered_reg;
  logic [5:0]  step_cnt_reg;
  logic [15:0] window_cnt_reg;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      filtered_reg   <= 1'b0;
      step_cnt_reg   <= 6'h00;
      window_cnt_reg <= 16'h0000;
    end else if (input_filter_window_reg == 16'h0000) begin
      filtered_reg   <= gpi_raw;
      step_cnt_reg   <= 6'h00;
      window_cnt_reg <= 16'h0000;
    end else if (gpi_raw == filtered_reg) begin
      step_cnt_reg   <= 6'h00;
      window_cnt_reg <= 16'h0000;
    end else if (step_cnt_reg == 6'(FILTER_STEP_CYC - 1)) begin
      step_cnt_reg <= 6'h00;
      if (window_cnt_reg + 16'h0001 >= input_filter_window_reg) begin
        filtered_reg   <= gpi_raw;
        window_cnt_reg <= 16'h0000;
      end else begin
        window_cnt_reg <= window_cnt_reg + 16'h0001;
      end
    end else begin
      step_cnt_reg <= step_cnt_reg + 6'h01;
    end
  end

  // ==========================================================================
  // Event path.
  // The pulse and the captured level leave together, so the level is valid whenever the pulse is seen.
  logic filtered_prev_reg;
  logic event_armed;
  logic input_change;

  assign event_armed = (logic_route_variable_reg == ROUTE_LOGIC_INPUT_ZERO)
                    && (event_source_select_reg == SOURCE_LOGIC_IRQ_QUEUE)
                    && (event_notify_mode_reg == NOTIFY_VISION_EVENT);
  assign input_change = filtered_reg ^ filtered_prev_reg;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      filtered_prev_reg       <= 1'b0;
      O_VISION_PROTOCOL_EVENT <= 1'b0;
      O_EVENT_LEVEL           <= 1'b0;
      event_count_reg         <= 16'h0000;
    end else begin
      filtered_prev_reg       <= filtered_reg;
      O_VISION_PROTOCOL_EVENT <= input_change && event_armed;
      if (input_change && event_armed) begin
        O_EVENT_LEVEL   <= filtered_reg;
        event_count_reg <= event_count_reg + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Sync channel: edge detect, stretch, relay and slow-mode frame division.
  // The edge detector resets to the idle low level of the pin, so no false pulse follows reset.
  // A new edge inside the microsecond restarts the stretch instead of adding a second pulse.
  logic       sync_prev_reg;
  logic       sync_rise;
  logic [6:0] stretch_cnt_reg;
  logic [7:0] div_cnt_reg;
  logic       sync_enabled;

  assign sync_rise    = sync_raw && !sync_prev_reg;
  assign sync_enabled = (frame_sync_setting_reg != SYNC_DISABLED);

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      sync_prev_reg   <= 1'b0;
      stretch_cnt_reg <= 7'h00;
      O_SYNC_OUT      <= 1'b0;
    end else begin
      sync_prev_reg <= sync_raw;
      if (sync_rise && sync_enabled) begin
        stretch_cnt_reg <= 7'(STRETCH_CYC - 1);
        O_SYNC_OUT      <= (frame_sync_setting_reg == SYNC_MASTER_RELAY);
      end else if (stretch_cnt_reg != 7'h00) begin
        stretch_cnt_reg <= stretch_cnt_reg - 7'h01;
      end else begin
        O_SYNC_OUT <= 1'b0;
      end
    end
  end

  // Slow configuration starts a frame on every (slow_divider_reg+1)th pulse, counted from zero at reset.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      div_cnt_reg   <= 8'h00;
      O_FRAME_START <= 1'b0;
    end else begin
      O_FRAME_START <= 1'b0;
      if (sync_rise && sync_enabled) begin
        if (div_cnt_reg >= slow_divider_reg) begin
          div_cnt_reg   <= 8'h00;
          O_FRAME_START <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 8'h01;
        end
      end
    end
  end

  assign O_GENERAL_OUTPUT_POSITIVE = general_output_value_reg;

  // ==========================================================================
  // AXI4-Lite write channel: address and data taken in either order.
  logic       aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic       w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] wstrb_held_reg;
  logic       wr_go;

  assign O_AWREADY = !aw_held_reg && !O_BVALID;
  assign O_WREADY  = !w_held_reg && !O_BVALID;
  assign wr_go     = aw_held_reg && w_held_reg;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg  <= 1'b0;
      w_data_reg  <= RESET_ZERO32;
      O_BVALID    <= 1'b0;
      O_BRESP     <= 2'h0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_held_reg <= 1'b1;
        w_data_reg <= I_WDATA;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        O_BVALID    <= 1'b1;
        O_BRESP     <= wr_known(aw_addr_reg) ? 2'h0 : 2'h2;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // Read-only and unmapped offsets answer with a slave error and change nothing.
  function automatic logic wr_known(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a == ADDR_OUTPUT_VALUE) begin
      ok = 1'b1;
    end else if (a == ADDR_ROUTE_VAR) begin
      ok = 1'b1;
    end else if (a == ADDR_EVENT_SELECT) begin
      ok = 1'b1;
    end else if (a == ADDR_NOTIFY_MODE) begin
      ok = 1'b1;
    end else if (a == ADDR_FILTER_WINDOW) begin
      ok = 1'b1;
    end else if (a == ADDR_SYNC_SETTING) begin
      ok = 1'b1;
    end else if (a == ADDR_SLOW_DIVIDER) begin
      ok = 1'b1;
    end else if (a == ADDR_IRQ_MASK) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  // Narrow fields are written only when the low-lane strobe is set; wide enums and the filter window take each strobed byte lane.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      general_output_value_reg <= 1'b0;
      logic_route_variable_reg <= RESET_ZERO32;
      event_source_select_reg  <= RESET_ZERO32;
      event_notify_mode_reg    <= RESET_ZERO32;
      input_filter_window_reg  <= 16'h0000;
      frame_sync_setting_reg   <= SYNC_DISABLED;
      slow_divider_reg         <= 8'h00;
      irq_mask_reg             <= '0;
    end else if (wr_go) begin
      if (aw_addr_reg == ADDR_OUTPUT_VALUE && wstrb_held_reg[0]) begin
        general_output_value_reg <= w_data_reg[0];
      end else if (aw_addr_reg == ADDR_ROUTE_VAR) begin
        logic_route_variable_reg <= merge(logic_route_variable_reg, w_data_reg, wstrb_held_reg);
      end else if (aw_addr_reg == ADDR_EVENT_SELECT) begin
        event_source_select_reg <= merge(event_source_select_reg, w_data_reg, wstrb_held_reg);
      end else if (aw_addr_reg == ADDR_NOTIFY_MODE) begin
        event_notify_mode_reg <= merge(event_notify_mode_reg, w_data_reg, wstrb_held_reg);
      end else if (aw_addr_reg == ADDR_FILTER_WINDOW) begin
        input_filter_window_reg <= 16'(merge({16'h0000, input_filter_window_reg}, w_data_reg, wstrb_held_reg));
      end else if (aw_addr_reg == ADDR_SYNC_SETTING && wstrb_held_reg[0]) begin
        frame_sync_setting_reg <= w_data_reg[1:0];
      end else if (aw_addr_reg == ADDR_SLOW_DIVIDER && wstrb_held_reg[0]) begin
        slow_divider_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg == ADDR_IRQ_MASK && wstrb_held_reg[0]) begin
        irq_mask_reg <= w_data_reg[IRQ_WIDTH-1:0];
      end
    end
  end

  // Strobes are kept with the data because the write lands only once both halves are in.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      wstrb_held_reg <= 4'h0;
    end else if (I_WVALID && O_WREADY) begin
      wstrb_held_reg <= I_WSTRB;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // AXI4-Lite read channel and sticky interrupt status.
  logic        status_read;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [IRQ_WIDTH-1:0] irq_events;

  assign O_ARREADY   = !O_RVALID;
  assign status_read = I_ARVALID && O_ARREADY && (I_ARADDR == ADDR_IRQ_STATUS);
  assign irq_events[IRQ_BIT_INPUT_EVENT] = O_VISION_PROTOCOL_EVENT;
  assign irq_events[IRQ_BIT_SYNC_PULSE]  = sync_rise && sync_enabled;
  assign irq_events[IRQ_BIT_FRAME_START] = O_FRAME_START;

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = RESET_ZERO32;
    if (I_ARADDR == ADDR_OUTPUT_VALUE) begin
      rd_word = {31'h0, general_output_value_reg};
    end else if (I_ARADDR == ADDR_LINE_STATE) begin
      rd_word = {31'h0, filtered_reg};
    end else if (I_ARADDR == ADDR_ROUTE_VAR) begin
      rd_word = logic_route_variable_reg;
    end else if (I_ARADDR == ADDR_EVENT_SELECT) begin
      rd_word = event_source_select_reg;
    end else if (I_ARADDR == ADDR_NOTIFY_MODE) begin
      rd_word = event_notify_mode_reg;
    end else if (I_ARADDR == ADDR_FILTER_WINDOW) begin
      rd_word = {16'h0, input_filter_window_reg};
    end else if (I_ARADDR == ADDR_SYNC_SETTING) begin
      rd_word = {30'h0, frame_sync_setting_reg};
    end else if (I_ARADDR == ADDR_SLOW_DIVIDER) begin
      rd_word = {24'h0, slow_divider_reg};
    end else if (I_ARADDR == ADDR_IRQ_STATUS) begin
      rd_word = {29'h0, irq_status_reg};
    end else if (I_ARADDR == ADDR_IRQ_MASK) begin
      rd_word = {29'h0, irq_mask_reg};
    end else if (I_ARADDR == ADDR_EVENT_COUNT) begin
      rd_word = {16'h0, event_count_reg};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_RVALID <= 1'b0;
      O_RDATA  <= RESET_ZERO32;
      O_RRESP  <= 2'h0;
    end else if (I_ARVALID && O_ARREADY) begin
      O_RVALID <= 1'b1;
      O_RDATA  <= rd_word;
      O_RRESP  <= rd_ok ? 2'h0 : 2'h2;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

  // A new event in the clearing cycle survives the read-clear.
  // The clear happens at the edge that captures the read data, so no event is lost between them.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (status_read ? '0 : irq_status_reg) | irq_events;
    end
  end

  // The interrupt is a level that drops once the status is read or its bit is masked.
  assign O_IRQ = |(irq_status_reg & irq_mask_reg);

endmodule

// File: sim/gdfs_checker.sv
// Port-level assertions for the general I/O debounce and frame sync block.
`timescale 1ns/10ps
module gdfs_checker (
  input wire logic        I_CLK_SYS,
  input wire logic        I_RST,
  input wire logic        I_SYNC_IN,
  input wire logic        I_GENERAL_INPUT_POSITIVE,
  input wire logic        I_BREADY,
  input wire logic        I_RREADY,
  input wire logic        O_BVALID,
  input wire logic [1:0]  O_BRESP,
  input wire logic        O_RVALID,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_ARREADY,
  input wire logic        O_GENERAL_OUTPUT_POSITIVE,
  input wire logic        O_SYNC_OUT,
  input wire logic        O_FRAME_START,
  input wire logic        O_VISION_PROTOCOL_EVENT,
  input wire logic        O_EVENT_LEVEL,
  input wire logic        O_IRQ
);
  logic [15:0] high_len_reg;
  logic [7:0]  sync_age_reg;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  // ==========================================================================
  // Helpers: length of the relay pulse, and cycles since the sync pin was high.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || !O_SYNC_OUT) high_len_reg <= 16'h0000;
    else high_len_reg <= high_len_reg + 16'h0001;
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || I_SYNC_IN) sync_age_reg <= 8'h00;
    else if (sync_age_reg != 8'hff) sync_age_reg <= sync_age_reg + 8'h01;
  end
  // ==========================================================================
  // Assertions.
  a_out_on_write:
    assert property ($changed(O_GENERAL_OUTPUT_POSITIVE) && !$past(I_RST) |-> $rose(O_BVALID))
    else $error("general output changed without a write response");
  a_sync_width:
    assert property ($fell(O_SYNC_OUT) |-> high_len_reg >= 16'd100)
    else $error("relayed sync pulse shorter than 100 cycles");
  a_sync_cause:
    assert property ($rose(O_SYNC_OUT) |-> sync_age_reg <= 8'd6)
    else $error("relayed sync pulse without a recent sync input");
  a_frame_cause:
    assert property (O_FRAME_START |-> sync_age_reg <= 8'd8 ##1 !O_FRAME_START)
    else $error("frame start not a single pulse after a sync input");
  a_event_single:
    assert property (O_VISION_PROTOCOL_EVENT |=> !O_VISION_PROTOCOL_EVENT)
    else $error("event message longer than one cycle");
  a_event_level:
    assert property (O_VISION_PROTOCOL_EVENT |-> O_EVENT_LEVEL == I_GENERAL_INPUT_POSITIVE)
    else $error("event level differs from the settled input");
  a_reset_quiet:
    assert property (disable iff (1'b0) I_RST |=> !O_SYNC_OUT && !O_FRAME_START && !O_IRQ && !O_BVALID)
    else $error("outputs active during reset");
  a_bresp_hold:
    assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped before it was taken");
  a_read_hold:
    assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA) && !O_ARREADY)
    else $error("read data dropped before it was taken");
endmodule

// File: sim/gdfs_far_end.sv
// Far-side model driving the opto-isolated general input and the sync input.
`timescale 1ns/10ps
module gdfs_far_end (
  input  wire logic i_clk,
  output logic      o_general_input,
  output logic      o_sync_in
);
  initial begin
    o_general_input = 1'b0;
    o_sync_in       = 1'b0;
  end
  task automatic set_level(input logic v, input int n);
    o_general_input <= v;
    repeat (n) @(posedge i_clk);
  endtask
  // The sync line idles low between pulses. Gaps are far shorter than a real
  // 29.97 Hz source gives, which keeps the run short.
  task automatic send_sync(input int width, input int gap);
    o_sync_in <= 1'b1;
    repeat (width) @(posedge i_clk);
    o_sync_in <= 1'b0;
    repeat (gap) @(posedge i_clk);
  endtask
endmodule

// File: sim/gdfs_top_tb.sv
// Self-checking testbench for the general I/O debounce and frame sync block.
`timescale 1ns/10ps
module gdfs_top_tb;
  import gdfs_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        awready, wready, bvalid, arready, rvalid, gpi, gpo, sync_in, sync_out, frame, ev, ev_lvl, irq;
  logic [15:0] lfsr = 16'd79;
  logic [31:0] model_reg [0:9];
  int          fail_count = 0;
  int          num_checks = 0;
  int          ev_seen = 0, fr_seen = 0, so_seen = 0, exp_ev = 0, exp_fr = 0, exp_so = 0;
  localparam logic [31:0] KEEP [0:9] = '{32'h1, 32'h0, '1, '1, '1, 32'hffff, 32'h3, 32'hff, 32'h0, 32'h7};

  gdfs_top i_gdfs_top (
    .I_CLK_SYS(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_GENERAL_INPUT_POSITIVE(gpi),
    .O_GENERAL_OUTPUT_POSITIVE(gpo), .I_SYNC_IN(sync_in), .O_SYNC_OUT(sync_out), .O_FRAME_START(frame),
    .O_VISION_PROTOCOL_EVENT(ev), .O_EVENT_LEVEL(ev_lvl), .O_IRQ(irq));
  gdfs_far_end i_far (.i_clk(clk), .o_general_input(gpi), .o_sync_in(sync_in));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    ev_seen <= ev_seen + int'(ev);
    fr_seen <= fr_seen + int'(frame);
    so_seen <= so_seen + int'(sync_out);
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The ready of the answer channel is raised only after valid is seen, so the hold time is exercised.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    bready <= 1'b1;
    @(posedge clk);
    check({29'h0, bvalid, bresp}, {29'h0, 1'b1, r});
    bready <= 1'b0;
    if (r == 2'b00) model_reg[a[5:2]] = d & KEEP[a[5:2]];
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rready <= 1'b1;
    @(posedge clk);
    check({29'h0, rvalid, rresp}, {29'h0, 1'b1, r});
    check(rdata, e);
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a);
    axi_rd(a, model_reg[a[5:2]], 2'b00);
  endtask
  task automatic toggle(input logic armed, input int hold);
    model_reg[1] = {31'h0, ~model_reg[1][0]};
    i_far.set_level(model_reg[1][0], hold);
    if (armed) exp_ev++;
    check(ev_seen, exp_ev);
    if (armed) check({31'h0, ev_lvl}, model_reg[1]);
    rd_chk(ADDR_LINE_STATE);
  endtask
  task automatic do_reset(input int n);
    foreach (model_reg[i]) model_reg[i] = 32'h0;
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    do_reset(10);
    for (int a = 0; a < 10; a++) rd_chk(8'(a * 4));
    axi_rd(8'h40, 32'h0, 2'b10);
    axi_wr(8'h40, 32'h1, 2'b10);
    axi_wr(ADDR_LINE_STATE, 32'h1, 2'b10);
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      axi_wr(ADDR_OUTPUT_VALUE, {16'h0, lfsr}, 2'b00);
      check({31'h0, gpo}, {31'h0, lfsr[0]});
      rd_chk(ADDR_OUTPUT_VALUE);
    end
    axi_wr(ADDR_ROUTE_VAR, ROUTE_LOGIC_INPUT_ZERO, 2'b00);
    axi_wr(ADDR_EVENT_SELECT, SOURCE_LOGIC_IRQ_QUEUE, 2'b00);
    rd_chk(ADDR_ROUTE_VAR);
    rd_chk(ADDR_EVENT_SELECT);
    for (int k = 0; k < 4; k++) begin
      axi_wr(ADDR_NOTIFY_MODE, 32'(k + 1), 2'b00);
      rd_chk(ADDR_NOTIFY_MODE);
      toggle(k == 2, 40);
    end
    axi_wr(ADDR_NOTIFY_MODE, NOTIFY_VISION_EVENT, 2'b00);
    check({31'h0, irq}, 32'h0);
    axi_wr(ADDR_IRQ_MASK, 32'h1, 2'b00);
    check({31'h0, irq}, 32'h1);
    axi_rd(ADDR_IRQ_STATUS, 32'h1, 2'b00);
    check({31'h0, irq}, 32'h0);
    axi_rd(ADDR_IRQ_STATUS, 32'h0, 2'b00);
    axi_wr(ADDR_FILTER_WINDOW, {16'h0, FILTER_WINDOW_MAX}, 2'b00);
    rd_chk(ADDR_FILTER_WINDOW);
    axi_wr(ADDR_FILTER_WINDOW, 32'h1, 2'b00);
    lfsr = lfsr_next(lfsr);
    // A glitch shorter than one 48-cycle step must leave no trace.
    i_far.set_level(1'b1, 10 + int'(lfsr[4:0]));
    i_far.set_level(1'b0, 100);
    check(ev_seen, exp_ev);
    rd_chk(ADDR_LINE_STATE);
    toggle(1'b1, 150);
    toggle(1'b1, 150);
    axi_rd(ADDR_EVENT_COUNT, 32'(exp_ev), 2'b00);
    for (int m = 0; m < 3; m++) begin
      axi_wr(ADDR_SYNC_SETTING, 32'(m), 2'b00);
      i_far.send_sync(10, 300);
      i_far.send_sync(10, 300);
      if (m != 0) exp_fr += 2;
      if (m == 2) exp_so += 2 * STRETCH_CYC;
      check(fr_seen, exp_fr);
      check(so_seen, exp_so);
    end
    axi_wr(ADDR_SLOW_DIVIDER, 32'h1, 2'b00);
    i_far.send_sync(10, 300);
    i_far.send_sync(10, 300);
    exp_fr += 1;
    exp_so += 2 * STRETCH_CYC;
    check(fr_seen, exp_fr);
    check(so_seen, exp_so);
    do_reset(2);
    rd_chk(ADDR_SYNC_SETTING);
    i_far.send_sync(10, 300);
    check(so_seen, exp_so);
    check(fr_seen, exp_fr);
    give_verdict();
  end
endmodule

bind gdfs_top gdfs_checker i_gdfs_checker (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_SYNC_IN(I_SYNC_IN),
  .I_GENERAL_INPUT_POSITIVE(I_GENERAL_INPUT_POSITIVE), .I_BREADY(I_BREADY), .I_RREADY(I_RREADY),
  .O_BVALID(O_BVALID), .O_BRESP(O_BRESP), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .O_ARREADY(O_ARREADY),
  .O_GENERAL_OUTPUT_POSITIVE(O_GENERAL_OUTPUT_POSITIVE), .O_SYNC_OUT(O_SYNC_OUT), .O_FRAME_START(O_FRAME_START),
  .O_VISION_PROTOCOL_EVENT(O_VISION_PROTOCOL_EVENT), .O_EVENT_LEVEL(O_EVENT_LEVEL), .O_IRQ(O_IRQ));
